/* File: wdrsc_ctrl.v */
`timescale 1ns/1ps
`include "wdrsc_defines.vh"

// How it works
// R01: Bit 6 of the reset and watchdog register selects normal (0) or high (1) drive on the PCI clocks, default 0.
// R02: With reset-on-timeout enabled in bit 4, every watchdog expiry fires a reset pulse, otherwise none.
// R03: With reset-on-frequency-change enabled in bit 3, every output frequency change fires a reset pulse.
// R04: The timeout flag in bit 2 reads 1 after an expiry, writing 1 clears it and writing 0 leaves it.
// R05: While the run enable in bit 1 is 0 the counter is stopped and reloaded with the programmed count.
// R06: With the run enable set, counting down starts only after an output frequency change.
// R07: The three-bit CPU offset field in bits 7 to 5 is driven to the CPU skew control.
// R08: The two-bit PCI offset field in bits 3 to 2 is driven to the PCI skew control, code 10 being reserved.
// R09: The two-bit AGP offset field in bits 1 to 0 is driven to the Agp_clock_offset control.
// R10: With recovery select set, the recovery frequency uses the programmed 8-bit N and 7-bit M values.
// R11: When the counter reaches zero the timeout flag is set.
// R12: The counter tick is 150 ms when the unit select is 0 and 2.5 s when it is 1.
// R13: A five-bit programmable count is held and is the value reloaded while the watchdog is disabled.
// R14: Reserved bits read as 0 and writes to them have no effect.
// R15: A set timeout flag stays set until software clears it, even if the watchdog is disabled.

module wdrsc_ctrl #(
  parameter SHORT_UNIT_CYC = `WDRSC_UNIT_SHORT_MS * `WDRSC_CLK_KHZ,
  parameter LONG_UNIT_CYC = `WDRSC_UNIT_LONG_MS * `WDRSC_CLK_KHZ,
  parameter TICK_W = 26,
  parameter RESET_PULSE_CYC = `WDRSC_RESET_PULSE_CYC
) (
  input wire ref_clk_in, // Device clock, 25 MHz.
  input wire rst_in, // Synchronous reset, active high.
  input wire ce_in, // Clock enable, low freezes all state.
  input wire [7:0] reg_addr_in, // Register byte offset from the serial engine.
  input wire [7:0] reg_wdata_in, // Write data.
  input wire reg_wr_in, // Write strobe, one cycle.
  input wire reg_rd_in, // Read strobe, one cycle.
  input wire freq_change_in, // Output frequency change, one-cycle pulse.
  output reg [7:0] reg_rdata_out, // Read data, updated on a read strobe.
  output wire pci_out_drive_strength_out, // PCI drive, 1 is high drive.
  output wire [2:0] cpu_clock_offset_out, // CPU skew code.
  output wire [1:0] pci_clock_offset_out, // PCI skew code.
  output wire [1:0] agp_clock_offset_out, // Agp_clock_offset code.
  output wire [7:0] recovery_divider_n_value_out, // Recovery N divider.
  output wire [6:0] recovery_divider_m_value_out, // Recovery M divider.
  output wire recovery_freq_select_out, // Recovery divider select.
  output wire recovery_active_out, // Recovery dividers in use.
  output reg timeout_pulse_out, // One-cycle pulse on each expiry.
  output wire timeout_flag_out, // Sticky timeout flag.
  output reg sys_reset_out // System reset pulse, active high.
);

  // --------------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------------
  localparam ST_STOP = 3'b001;
  localparam ST_ARMED = 3'b010;
  localparam ST_COUNT = 3'b100;
  localparam PULSE_W = 8;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [4:0] timeout_count;
  reg timeout_unit_select;
  reg pci_drive;
  reg reset_on_timeout_enable;
  reg reset_on_freq_change_enable;
  reg timeout_flag;
  reg timer_run_enable;
  reg [7:0] skew;
  reg [7:0] recov_n;
  reg [6:0] recov_m;
  reg recov_sel;
  reg [4:0] count;
  reg [4:0] next_count;
  reg [PULSE_W-1:0] pulse_cnt;
  wire tick;
  wire expire;
  wire wr_rw;

  // Address decode shared by the write and read paths.
  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Watchdog unit tick
  // --------------------------------------------------------------------------
  // The tick restarts whenever the counter is not running, so each count is a full unit.
  wdrsc_tick #(
    .CNT_W(TICK_W),
    .SHORT_CYC(SHORT_UNIT_CYC),
    .LONG_CYC(LONG_UNIT_CYC)
  ) u_tick (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .clear_in(state != ST_COUNT || freq_change_in),
    .unit_sel_in(timeout_unit_select),
    .tick_out(tick)
  );

  assign wr_rw = reg_wr_in && hit(reg_addr_in, `WDRSC_ADDR_RESET_WD);
  assign expire = state == ST_COUNT && tick && count <= 5'h01; // [R11]

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  // Only the defined fields are stored, so reserved bits can never be set.
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      timeout_count <= `WDRSC_RST_TIMEOUT_COUNT;
      timeout_unit_select <= `WDRSC_RST_UNIT_SEL;
      pci_drive <= 1'b0;
      reset_on_timeout_enable <= 1'b0;
      reset_on_freq_change_enable <= 1'b0;
      timer_run_enable <= 1'b0;
      skew <= `WDRSC_RST_BYTE;
      recov_n <= `WDRSC_RST_BYTE;
      recov_m <= `WDRSC_RST_M;
      recov_sel <= 1'b0;
    end else if (ce_in && reg_wr_in) begin
      if (hit(reg_addr_in, `WDRSC_ADDR_TIMEOUT_CFG)) begin
        timeout_count <= reg_wdata_in[`WDRSC_CFG_COUNT_MSB:`WDRSC_CFG_COUNT_LSB]; // [R13]
        timeout_unit_select <= reg_wdata_in[`WDRSC_CFG_UNIT_BIT]; // [R12]
      end
      if (wr_rw) begin
        pci_drive <= reg_wdata_in[`WDRSC_RW_DRIVE_BIT]; // [R01]
        reset_on_timeout_enable <= reg_wdata_in[`WDRSC_RW_RST_TO_BIT];
        reset_on_freq_change_enable <= reg_wdata_in[`WDRSC_RW_RST_FC_BIT];
        timer_run_enable <= reg_wdata_in[`WDRSC_RW_RUN_BIT];
      end
      if (hit(reg_addr_in, `WDRSC_ADDR_SKEW)) begin
        skew <= reg_wdata_in & 8'hEF; // [R14]
      end
      if (hit(reg_addr_in, `WDRSC_ADDR_RECOV_N)) begin
        recov_n <= reg_wdata_in;
      end
      if (hit(reg_addr_in, `WDRSC_ADDR_RECOV_M)) begin
        recov_m <= reg_wdata_in[`WDRSC_M_VAL_MSB:0];
        recov_sel <= reg_wdata_in[`WDRSC_M_SEL_BIT];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Timeout flag
  // --------------------------------------------------------------------------
  // An expiry in the same cycle as a clearing write wins, so no timeout is lost.
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      timeout_flag <= 1'b0;
    end else if (ce_in) begin
      if (expire) begin
        timeout_flag <= 1'b1; // [R11] [R15]
      end else if (wr_rw && reg_wdata_in[`WDRSC_RW_FLAG_BIT]) begin
        timeout_flag <= 1'b0; // [R04]
      end
    end
  end

  // --------------------------------------------------------------------------
  // Watchdog state machine
  // --------------------------------------------------------------------------
  // Disable takes effect on the cycle after the write, matching the stored enable bit.
  always @* begin
    next_state = state;
    next_count = count;
    case (state)
      ST_STOP: begin
        next_count = timeout_count; // [R05] [R13]
        if (timer_run_enable) begin
          next_state = ST_ARMED;
        end
      end
      ST_ARMED: begin
        next_count = timeout_count;
        if (!timer_run_enable) begin
          next_state = ST_STOP;
        end else if (freq_change_in) begin
          next_state = ST_COUNT; // [R06]
        end
      end
      ST_COUNT: begin
        if (!timer_run_enable) begin
          next_state = ST_STOP; // [R05]
          next_count = timeout_count;
        end else if (freq_change_in) begin
          next_count = timeout_count;
        end else if (expire) begin
          next_state = ST_ARMED;
          next_count = timeout_count;
        end else if (tick) begin
          next_count = count - 5'h01; // [R12]
        end
      end
      default: begin
        next_state = ST_STOP;
        next_count = timeout_count;
      end
    endcase
  end

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      state <= ST_STOP;
      count <= `WDRSC_RST_TIMEOUT_COUNT;
      timeout_pulse_out <= 1'b0;
    end else if (ce_in) begin
      state <= next_state;
      count <= next_count;
      timeout_pulse_out <= expire;
    end
  end

  // --------------------------------------------------------------------------
  // System reset pulse
  // --------------------------------------------------------------------------
  // A new request restarts the pulse rather than stacking, so overlap yields one longer pulse.
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      pulse_cnt <= {PULSE_W{1'b0}};
      sys_reset_out <= 1'b0;
    end else if (ce_in) begin
      if ((expire && reset_on_timeout_enable) // [R02]
          || (freq_change_in && reset_on_freq_change_enable)) begin // [R03]
        pulse_cnt <= RESET_PULSE_CYC[PULSE_W-1:0];
        sys_reset_out <= 1'b1;
      end else if (pulse_cnt > {{(PULSE_W-1){1'b0}}, 1'b1}) begin
        pulse_cnt <= pulse_cnt - 1'b1;
      end else begin
        pulse_cnt <= {PULSE_W{1'b0}};
        sys_reset_out <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------------
  // Unmapped offsets and reserved bits read as zero.
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= `WDRSC_RST_BYTE;
    end else if (ce_in && reg_rd_in) begin
      if (hit(reg_addr_in, `WDRSC_ADDR_TIMEOUT_CFG)) begin
        reg_rdata_out <= {2'h0, timeout_count, timeout_unit_select};
      end else if (hit(reg_addr_in, `WDRSC_ADDR_RESET_WD)) begin
        reg_rdata_out <= {1'b0, pci_drive, 1'b0, reset_on_timeout_enable, reset_on_freq_change_enable,
                          timeout_flag, timer_run_enable, 1'b0}; // [R04] [R14]
      end else if (hit(reg_addr_in, `WDRSC_ADDR_SKEW)) begin
        reg_rdata_out <= skew;
      end else if (hit(reg_addr_in, `WDRSC_ADDR_RECOV_N)) begin
        reg_rdata_out <= recov_n;
      end else if (hit(reg_addr_in, `WDRSC_ADDR_RECOV_M)) begin
        reg_rdata_out <= {recov_sel, recov_m};
      end else begin
        reg_rdata_out <= `WDRSC_RST_BYTE;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Control outputs
  // --------------------------------------------------------------------------
  // Code 10 on the PCI field is passed through; the skew logic must treat it as reserved.
  assign pci_out_drive_strength_out = pci_drive; // [R01]
  assign cpu_clock_offset_out = skew[`WDRSC_SK_CPU_MSB:`WDRSC_SK_CPU_LSB]; // [R07]
  assign pci_clock_offset_out = skew[`WDRSC_SK_PCI_MSB:`WDRSC_SK_PCI_LSB]; // [R08]
  assign agp_clock_offset_out = skew[`WDRSC_SK_AGP_MSB:`WDRSC_SK_AGP_LSB]; // [R09]
  assign recovery_divider_n_value_out = recov_n;
  assign recovery_divider_m_value_out = recov_m;
  assign recovery_freq_select_out = recov_sel;
  assign recovery_active_out = recov_sel && timeout_flag; // [R10]
  assign timeout_flag_out = timeout_flag;

endmodule

/* File: wdrsc_defines.vh */
`ifndef WDRSC_DEFINES_VH
`define WDRSC_DEFINES_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define WDRSC_ADDR_TIMEOUT_CFG 8'h04
`define WDRSC_ADDR_RESET_WD 8'h09
`define WDRSC_ADDR_SKEW 8'h0A
`define WDRSC_ADDR_RECOV_N 8'h0B
`define WDRSC_ADDR_RECOV_M 8'h0C

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define WDRSC_RST_TIMEOUT_COUNT 5'h1F
`define WDRSC_RST_UNIT_SEL 1'h0
`define WDRSC_RST_BYTE 8'h00
`define WDRSC_RST_M 7'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define WDRSC_CFG_UNIT_BIT 0
`define WDRSC_CFG_COUNT_LSB 1
`define WDRSC_CFG_COUNT_MSB 5
`define WDRSC_RW_DRIVE_BIT 6
`define WDRSC_RW_RST_TO_BIT 4
`define WDRSC_RW_RST_FC_BIT 3
`define WDRSC_RW_FLAG_BIT 2
`define WDRSC_RW_RUN_BIT 1
`define WDRSC_SK_CPU_LSB 5
`define WDRSC_SK_CPU_MSB 7
`define WDRSC_SK_PCI_LSB 2
`define WDRSC_SK_PCI_MSB 3
`define WDRSC_SK_AGP_LSB 0
`define WDRSC_SK_AGP_MSB 1
`define WDRSC_M_SEL_BIT 7
`define WDRSC_M_VAL_MSB 6

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define WDRSC_CLK_KHZ 25000
`define WDRSC_UNIT_SHORT_MS 150
`define WDRSC_UNIT_LONG_MS 2500
`define WDRSC_RESET_PULSE_CYC 16

`endif

/* File: wdrsc_tick.v */
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Watchdog unit tick generator
// ----------------------------------------------------------------------------
module wdrsc_tick #(
  parameter CNT_W = 26,
  parameter SHORT_CYC = 3750000,
  parameter LONG_CYC = 62500000
) (
  input wire ref_clk_in, // Device clock.
  input wire rst_in, // Synchronous reset, active high.
  input wire ce_in, // Clock enable.
  input wire clear_in, // Restart the unit interval.
  input wire unit_sel_in, // 0 short unit, 1 long unit.
  output reg tick_out // One-cycle pulse at the end of each unit.
);

  reg [CNT_W-1:0] cnt;
  wire [CNT_W-1:0] last;

  // The terminal count follows the unit select live, so a change takes effect within one unit.
  assign last = unit_sel_in ? LONG_CYC[CNT_W-1:0] - 1'b1 : SHORT_CYC[CNT_W-1:0] - 1'b1;

  // Free count that restarts on clear, so the first unit is always whole.
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      cnt <= {CNT_W{1'b0}};
      tick_out <= 1'b0;
    end else if (ce_in) begin
      if (clear_in || cnt >= last) begin
        cnt <= {CNT_W{1'b0}};
      end else begin
        cnt <= cnt + 1'b1;
      end
      tick_out <= !clear_in && cnt >= last; // [R12]
    end
  end

endmodule

/* File: wdrsc_ctrl_properties.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Port checker for the watchdog and skew control block
// ----------------------------------------------------------------------------
module wdrsc_ctrl_properties #(
  parameter RESET_PULSE_CYC = 16
) (
  input wire ref_clk_in, // Device clock.
  input wire rst_in, // Synchronous reset.
  input wire ce_in, // Clock enable.
  input wire [7:0] reg_addr_in, // Register offset.
  input wire [7:0] reg_wdata_in, // Write data.
  input wire reg_wr_in, // Write strobe.
  input wire freq_change_in, // Frequency change event.
  input wire pci_out_drive_strength_out, // PCI drive.
  input wire [2:0] cpu_clock_offset_out, // CPU skew code.
  input wire [1:0] pci_clock_offset_out, // PCI skew code.
  input wire [1:0] agp_clock_offset_out, // Agp_clock_offset code.
  input wire recovery_freq_select_out, // Recovery select.
  input wire recovery_active_out, // Recovery in use.
  input wire timeout_pulse_out, // Expiry pulse.
  input wire timeout_flag_out, // Sticky flag.
  input wire sys_reset_out // System reset pulse.
);
  integer hi_cnt;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // Counts how long the reset output has stood high, so a short pulse is caught.
  always @(posedge ref_clk_in) begin
    if (rst_in || !sys_reset_out) begin
      hi_cnt <= 0;
    end else begin
      hi_cnt <= hi_cnt + 1;
    end
  end
  // A write taken at one offset on an enabled edge.
  sequence s_wr(a);
    ce_in && reg_wr_in && reg_addr_in == a;
  endsequence
  property p_drive;
    s_wr(8'h09) |=> pci_out_drive_strength_out == $past(reg_wdata_in[6]);
  endproperty
  a_drive: assert property (p_drive) else $error("drive bit not taken");
  property p_cpu;
    s_wr(8'h0A) |=> cpu_clock_offset_out == $past(reg_wdata_in[7:5]);
  endproperty
  a_cpu: assert property (p_cpu) else $error("cpu offset not taken");
  property p_pci;
    s_wr(8'h0A) |=> pci_clock_offset_out == $past(reg_wdata_in[3:2]);
  endproperty
  a_pci: assert property (p_pci) else $error("pci offset not taken");
  property p_agp;
    s_wr(8'h0A) |=> agp_clock_offset_out == $past(reg_wdata_in[1:0]);
  endproperty
  a_agp: assert property (p_agp) else $error("agp offset not taken");
  property p_flag_set;
    $rose(timeout_flag_out) |-> timeout_pulse_out;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag rose without expiry");
  property p_clear;
    $fell(timeout_flag_out) |-> $past(ce_in && reg_wr_in && reg_addr_in == 8'h09 && reg_wdata_in[2]);
  endproperty
  a_clear: assert property (p_clear) else $error("flag fell without clear");
  property p_rst_cause;
    $rose(sys_reset_out) |-> $past(freq_change_in && ce_in) || timeout_pulse_out;
  endproperty
  a_rst_cause: assert property (p_rst_cause) else $error("reset pulse without cause");
  property p_rst_width;
    $fell(sys_reset_out) |-> hi_cnt >= RESET_PULSE_CYC;
  endproperty
  a_rst_width: assert property (p_rst_width) else $error("reset pulse too short");
  property p_recov;
    recovery_active_out == (recovery_freq_select_out && timeout_flag_out);
  endproperty
  a_recov: assert property (p_recov) else $error("recovery use mismatch");
endmodule

bind wdrsc_ctrl wdrsc_ctrl_properties #(.RESET_PULSE_CYC(RESET_PULSE_CYC)) i_props (.ref_clk_in, .rst_in, .ce_in,
  .reg_addr_in, .reg_wdata_in, .reg_wr_in, .freq_change_in, .pci_out_drive_strength_out, .cpu_clock_offset_out,
  .pci_clock_offset_out, .agp_clock_offset_out, .recovery_freq_select_out, .recovery_active_out,
  .timeout_pulse_out, .timeout_flag_out, .sys_reset_out);

/* File: wdrsc_host_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Host side of the byte register port
// ----------------------------------------------------------------------------
module wdrsc_host_model (
  input wire ref_clk_in, // Device clock.
  input wire [7:0] reg_rdata_in, // Read data from the device.
  output reg [7:0] reg_addr_out, // Register offset.
  output reg [7:0] reg_wdata_out, // Write data.
  output reg reg_wr_out, // Write strobe.
  output reg reg_rd_out // Read strobe.
);
  // Idle lines carry inverted junk so a stale value is never read as valid.
  initial begin
    reg_addr_out = 8'hFF;
    reg_wdata_out = 8'hFF;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end
  // One byte write, strobe held for one sampled edge.
  task automatic wr(input [7:0] a, input [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_out <= 1'b0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
  endtask
  // One byte read, data taken one edge after the strobe is sampled.
  task automatic rd(input [7:0] a, output [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~a;
    @(posedge ref_clk_in);
    d = reg_rdata_in;
  endtask
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
  reg ref_clk_in = 1'b0;
  reg rst_in = 1'b1;
  reg ce_in = 1'b1;
  reg freq_change_in = 1'b0;
  wire [7:0] addr, wdata, rdata, n_val;
  wire [6:0] m_val;
  wire [2:0] cpu;
  wire [1:0] pci, agp;
  wire wr, rd, drive, rsel, ract, tpulse, flag, sysr;
  integer errors = 0, tests_run = 0, cyc = 0, i, t0, w;
  integer regs [0:255];
  reg [7:0] got, d;
  wdrsc_ctrl #(.SHORT_UNIT_CYC(4), .LONG_UNIT_CYC(8), .RESET_PULSE_CYC(4)) i_wdrsc_ctrl (.ref_clk_in(ref_clk_in),
    .rst_in(rst_in), .ce_in(ce_in), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .freq_change_in(freq_change_in), .reg_rdata_out(rdata), .pci_out_drive_strength_out(drive),
    .cpu_clock_offset_out(cpu), .pci_clock_offset_out(pci), .agp_clock_offset_out(agp),
    .recovery_divider_n_value_out(n_val), .recovery_divider_m_value_out(m_val), .recovery_freq_select_out(rsel),
    .recovery_active_out(ract), .timeout_pulse_out(tpulse), .timeout_flag_out(flag), .sys_reset_out(sysr));
  wdrsc_host_model i_wdrsc_host_model (.ref_clk_in(ref_clk_in), .reg_rdata_in(rdata), .reg_addr_out(addr),
    .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd));
  // ----------------------------------------------------------------------------
  // Clock, hang guard and shared tasks
  // ----------------------------------------------------------------------------
  initial begin
    forever #20 ref_clk_in = ~ref_clk_in;
  end
  // The whole run needs about 330 cycles, so a far larger ceiling means a hang.
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      report_and_stop;
    end
  end
  task chk(input [7:0] g, input [7:0] e);
    tests_run = tests_run + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task report_and_stop;
    $display("checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Writes a byte and keeps the register model in step, reserved bits and the offset 04 unit select bit dropped.
  task wreg(input [7:0] a, input [7:0] v);
    i_wdrsc_host_model.wr(a, v);
    case (a)
      8'h04: regs[4] = v & 8'h3E;
      8'h09: regs[9] = (v & 8'h5A) | (regs[9] & 8'h04 & ~(v & 8'h04));
      8'h0A: regs[10] = v & 8'hEF;
      8'h0B, 8'h0C: regs[a] = v;
      default: ;
    endcase
    @(negedge ref_clk_in);
  endtask
  task rchk(input [7:0] a);
    i_wdrsc_host_model.rd(a, got);
    chk(got, regs[a]);
  endtask
  task fc;
    @(posedge ref_clk_in);
    freq_change_in <= 1'b1;
    @(posedge ref_clk_in);
    freq_change_in <= 1'b0;
    t0 = cyc;
  endtask
  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    for (i = 0; i < 256; i = i + 1) regs[i] = 0;
    regs[4] = 8'h3E;
    w = $urandom(19);
    repeat (4) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    for (i = 0; i < 16; i = i + 1) rchk(i);
    $display("test 1 done");
    for (i = 0; i < 8; i = i + 1) begin
      w = $urandom;
      d = {i[2:0], w[4:0]};
      if (d[3:2] == 2'b10) d[2] = 1'b1;
      wreg(8'h0A, d);
      chk({cpu, 1'b0, pci, agp}, regs[10]);
      rchk(8'h0A);
      wreg(8'h09, $urandom);
      chk(drive, regs[9] >> 6);
      rchk(8'h09);
      wreg(8'h0B, $urandom);
      wreg(8'h0C, $urandom);
      chk(n_val, regs[11]);
      chk({rsel, m_val}, regs[12]);
    end
    wreg(8'h0C, 8'h85);
    $display("test 2 done");
    for (i = 0; i < 2; i = i + 1) begin
      wreg(8'h04, {2'b00, 5'd2, i[0]});
      wreg(8'h09, i ? 8'h02 : 8'h12);
      repeat (20) @(negedge ref_clk_in);
      chk(flag, 0);
      fc;
      w = 0;
      while (tpulse !== 1'b1 && w < 100) begin
        @(negedge ref_clk_in);
        w = w + 1;
      end
      w = cyc - t0 - 2 * (i ? 8 : 4);
      chk(w >= 0 && w <= 4, 1);
      chk(sysr, !i);
      chk(ract, 1);
      regs[9] = regs[9] | 8'h04;
      rchk(8'h09);
      wreg(8'h09, 8'h00);
      rchk(8'h09);
      wreg(8'h09, 8'h04);
      rchk(8'h09);
      chk(ract, 0);
    end
    fc;
    repeat (30) @(negedge ref_clk_in);
    chk(flag, 0);
    $display("test 3 done");
    wreg(8'h09, 8'h08);
    fc;
    repeat (2) @(negedge ref_clk_in);
    chk(sysr, 1);
    repeat (6) @(negedge ref_clk_in);
    chk(sysr, 0);
    wreg(8'h09, 8'h00);
    fc;
    repeat (3) @(negedge ref_clk_in);
    chk(sysr, 0);
    // A write offered while the clock enable is low must be lost, so the skew outputs keep their value.
    @(posedge ref_clk_in);
    ce_in <= 1'b0;
    i_wdrsc_host_model.wr(8'h0A, 8'h00);
    @(posedge ref_clk_in);
    ce_in <= 1'b1;
    @(negedge ref_clk_in);
    chk({cpu, 1'b0, pci, agp}, regs[10]);
    $display("test 4 done");
    report_and_stop;
  end
endmodule
